// [logic/sap_map.svh]
// constants for the command decoder: codes, status words, lengths
// included by the package and by both ends
`ifndef SAP_MAP_SVH
`define SAP_MAP_SVH
`define SAP_CLA_GSM 8'hA0
`define SAP_INS_SELECT 8'hA4
`define SAP_INS_STATUS 8'hF2
`define SAP_INS_RD_BIN 8'hB0
`define SAP_INS_UPD_BIN 8'hD6
`define SAP_INS_RD_REC 8'hB2
`define SAP_INS_UPD_REC 8'hDC
`define SAP_INS_SEEK 8'hA2
`define SAP_INS_INCR 8'h32
`define SAP_INS_VERIFY 8'h20
`define SAP_INS_CHANGE 8'h24
`define SAP_INS_DISABLE 8'h26
`define SAP_INS_ENABLE 8'h28
`define SAP_INS_UNBLOCK 8'h2C
`define SAP_INS_INVAL 8'h04
`define SAP_INS_REHAB 8'h44
`define SAP_INS_RUN_ALG 8'h88
`define SAP_INS_SLEEP 8'hFA
`define SAP_INS_GET_RESP 8'hC0
`define SAP_INS_TERM_PROF 8'h10
`define SAP_INS_ENVELOPE 8'hC2
`define SAP_INS_FETCH 8'h12
`define SAP_INS_TERM_RESP 8'h14
`define SAP_PZERO 8'h00
`define SAP_P2_ONE 8'h01
`define SAP_P2_CODE2 8'h02
`define SAP_P3_SELECT 8'h02
`define SAP_P3_INCR 8'h03
`define SAP_P3_CODE8 8'h08
`define SAP_P3_CODE16 8'h10
`define SAP_SW1_OK 8'h90
`define SAP_SW1_PEND 8'h9F
`define SAP_SW1_PEND_DL 8'h9E
`define SAP_SW1_ERR_CLA 8'h6E
`define SAP_SW1_ERR_INS 8'h6D
`define SAP_SW1_ERR_P12 8'h6B
`define SAP_SW1_ERR_P3 8'h67
`define SAP_SW2_ZERO 8'h00
`define SAP_HDR_LAST 3'h4
`define SAP_LEN_MAX 9'h100
`define SAP_LEN_ONE 9'h001
`endif

// [logic/sap_pkg.sv]
// types and command table shared by the card and terminal ends
// relies on sap_map.svh for every code
`include "sap_map.svh"
package sap_pkg;
  typedef enum logic [1:0] {
    SAP_DIR_NONE = 2'b00,
    SAP_DIR_IN = 2'b01,
    SAP_DIR_OUT = 2'b10,
    SAP_DIR_BAD = 2'b11
  } sap_dir_e;
  typedef enum logic [2:0] {
    SAP_C_HDR = 3'b000,
    SAP_C_RXD = 3'b001,
    SAP_C_TXD = 3'b010,
    SAP_C_SW1 = 3'b011,
    SAP_C_SW2 = 3'b100
  } sap_card_st_e;
  typedef enum logic [1:0] {
    SAP_H_IDLE = 2'b00,
    SAP_H_HDR = 2'b01,
    SAP_H_TXD = 2'b10,
    SAP_H_RXW = 2'b11
  } sap_host_st_e;

  // data direction of each instruction; reserved and unknown are bad
  function automatic sap_dir_e sap_dir(input logic [7:0] ins);
    case (ins)
      `SAP_INS_STATUS, `SAP_INS_RD_BIN, `SAP_INS_RD_REC,
      `SAP_INS_GET_RESP, `SAP_INS_FETCH:
        sap_dir = SAP_DIR_OUT;
      `SAP_INS_SELECT, `SAP_INS_UPD_BIN, `SAP_INS_UPD_REC, `SAP_INS_SEEK,
      `SAP_INS_INCR, `SAP_INS_VERIFY, `SAP_INS_CHANGE, `SAP_INS_DISABLE,
      `SAP_INS_ENABLE, `SAP_INS_UNBLOCK, `SAP_INS_RUN_ALG,
      `SAP_INS_TERM_PROF, `SAP_INS_ENVELOPE, `SAP_INS_TERM_RESP:
        sap_dir = SAP_DIR_IN;
      `SAP_INS_INVAL, `SAP_INS_REHAB, `SAP_INS_SLEEP:
        sap_dir = SAP_DIR_NONE;
      default:
        sap_dir = SAP_DIR_BAD;
    endcase
  endfunction

  // commands whose output length is announced by the status words
  function automatic logic sap_pend(input logic [7:0] ins);
    case (ins)
      `SAP_INS_SELECT, `SAP_INS_SEEK, `SAP_INS_INCR, `SAP_INS_RUN_ALG,
      `SAP_INS_ENVELOPE:
        sap_pend = 1'b1;
      default:
        sap_pend = 1'b0;
    endcase
  endfunction
endpackage

// [logic/sap_if.sv]
// byte link between terminal and card, one byte a cycle each way
// both ends run on the same clock; no back-pressure on either side
`timescale 1ns/1ps
interface sap_if;
  logic t2c_valid;
  logic [7:0] t2c_byte;
  logic c2t_valid;
  logic [7:0] c2t_byte;
  logic c2t_sw;
  modport card (
    input t2c_valid,
    input t2c_byte,
    output c2t_valid,
    output c2t_byte,
    output c2t_sw
  );
  modport term (
    output t2c_valid,
    output t2c_byte,
    input c2t_valid,
    input c2t_byte,
    input c2t_sw
  );
endinterface

// [logic/sap_card.sv]
// card end: collects header and data, decodes, answers status words
// assumes the terminal sends one well-spaced command at a time
//
// Contract
// R1 - header five bytes, data, then two status
// R2 - class A0 marks the gsm application
// R3 - P3 length; 00 is 256 out, none in
// R4 - FF legal in P1, P2, P3
// R5 - bytes pass unchanged, no extra framing
// R6 - unknown output length answers 9F with length
// R7 - terminal fetches pending data with C0
// R8 - envelope download may answer 9E with length
// R9 - other class leaves application state untouched
// R10 - offset is P1 high, P2 low
// R11 - 1X even 6 to E reserved
// R12 - administrative codes reserved, never decoded
// R13 - select A4, 00 00 02, two id bytes
// R14 - binary, record, seek, increase codes decoded
// R15 - secret code commands and their lengths
// R16 - unblock P2 00 first, 02 second
// R17 - get response carries no input data
// R18 - move exactly P3 bytes before status
// R19 - unknown code gets error, no data
`timescale 1ns/1ps
`include "sap_map.svh"
module sap_card (
  input wire logic sys_clk,
  input wire logic reset_n,
  sap_if.card lnk,
  output logic cmd_go,
  output logic [7:0] cmd_ins,
  output logic [7:0] cmd_p1,
  output logic [7:0] cmd_p2,
  output logic [7:0] cmd_p3,
  output logic [15:0] cmd_offset,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic tx_take,
  input wire logic [7:0] tx_byte,
  input wire logic [7:0] pend_len,
  input wire logic dl_pend
);
  sap_pkg::sap_card_st_e st_reg;
  logic [2:0] hcnt_reg;
  logic [8:0] len_reg;
  logic [7:0] cla_reg;
  logic [7:0] ins_reg;
  logic [7:0] p1_reg;
  logic [7:0] p2_reg;
  logic [7:0] sw1_reg;
  logic [7:0] sw2_reg;
  logic ok_reg;
  logic pend_reg;
  logic dl_reg;
  logic hdr_done;
  logic [7:0] p3_now;
  sap_pkg::sap_dir_e dir_now;
  logic p12_bad;
  logic p3_bad;
  logic chk_ok;
  logic [7:0] chk_sw1;
  logic [7:0] sw1_out;
  logic [7:0] sw2_out;
  logic rx_last;

  assign p3_now = lnk.t2c_byte;
  assign hdr_done = (st_reg == sap_pkg::SAP_C_HDR) && lnk.t2c_valid &&
                    (hcnt_reg == `SAP_HDR_LAST);
  assign dir_now = sap_pkg::sap_dir(ins_reg); // R11 R12 R19
  assign rx_last = (st_reg == sap_pkg::SAP_C_RXD) && lnk.t2c_valid &&
                   (len_reg == `SAP_LEN_ONE);

  // fixed parameter checks; any other value, FF included, is legal
  always_comb
  begin
    p12_bad = 1'b0;
    p3_bad = 1'b0;
    case (ins_reg)
      `SAP_INS_SELECT:
      begin
        p12_bad = (p1_reg != `SAP_PZERO) || (p2_reg != `SAP_PZERO); // R13
        p3_bad = p3_now != `SAP_P3_SELECT; // R13
      end
      `SAP_INS_INCR:
        p3_bad = p3_now != `SAP_P3_INCR; // R14
      `SAP_INS_VERIFY:
        p3_bad = p3_now != `SAP_P3_CODE8; // R15
      `SAP_INS_DISABLE, `SAP_INS_ENABLE:
      begin
        p12_bad = p2_reg != `SAP_P2_ONE; // R15
        p3_bad = p3_now != `SAP_P3_CODE8; // R15
      end
      `SAP_INS_CHANGE:
        p3_bad = p3_now != `SAP_P3_CODE16; // R15
      `SAP_INS_UNBLOCK:
      begin
        p12_bad = (p2_reg != `SAP_PZERO) &&
                  (p2_reg != `SAP_P2_CODE2); // R16
        p3_bad = p3_now != `SAP_P3_CODE16; // R15
      end
      `SAP_INS_RUN_ALG:
        p3_bad = p3_now != `SAP_P3_CODE16;
      `SAP_INS_INVAL, `SAP_INS_REHAB, `SAP_INS_SLEEP:
        p3_bad = p3_now != `SAP_PZERO;
      default:
      begin
        p12_bad = 1'b0;
        p3_bad = 1'b0;
      end
    endcase
  end

  // status chosen at the fifth header byte, class checked first
  always_comb
  begin
    chk_ok = 1'b0;
    if (cla_reg != `SAP_CLA_GSM)
      chk_sw1 = `SAP_SW1_ERR_CLA; // R2 R9
    else if (dir_now == sap_pkg::SAP_DIR_BAD)
      chk_sw1 = `SAP_SW1_ERR_INS; // R19
    else if (p12_bad)
      chk_sw1 = `SAP_SW1_ERR_P12;
    else if (p3_bad)
      chk_sw1 = `SAP_SW1_ERR_P3;
    else
    begin
      chk_sw1 = `SAP_SW1_OK;
      chk_ok = 1'b1;
    end
  end

  assign sw1_out = !pend_reg ? sw1_reg :
                   (dl_reg && dl_pend) ? `SAP_SW1_PEND_DL : // R8
                   `SAP_SW1_PEND; // R6
  assign sw2_out = pend_reg ? pend_len : sw2_reg; // R6

  // header capture, length counting and sequencing
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg <= sap_pkg::SAP_C_HDR;
      hcnt_reg <= 3'h0;
      len_reg <= 9'h000;
      cla_reg <= 8'h00;
      ins_reg <= 8'h00;
      p1_reg <= 8'h00;
      p2_reg <= 8'h00;
      sw1_reg <= 8'h00;
      sw2_reg <= 8'h00;
      ok_reg <= 1'b0;
      pend_reg <= 1'b0;
      dl_reg <= 1'b0;
    end
    else
    begin
      case (st_reg)
        sap_pkg::SAP_C_HDR:
          if (lnk.t2c_valid)
          begin
            hcnt_reg <= hdr_done ? 3'h0 : hcnt_reg + 3'h1; // R1
            case (hcnt_reg)
              3'h0: cla_reg <= lnk.t2c_byte;
              3'h1: ins_reg <= lnk.t2c_byte;
              3'h2: p1_reg <= lnk.t2c_byte;
              3'h3: p2_reg <= lnk.t2c_byte;
              default: ;
            endcase
            if (hdr_done)
            begin
              sw1_reg <= chk_sw1;
              sw2_reg <= `SAP_SW2_ZERO;
              ok_reg <= chk_ok;
              pend_reg <= chk_ok && sap_pkg::sap_pend(ins_reg); // R6 R13
              dl_reg <= ins_reg == `SAP_INS_ENVELOPE; // R8
              if (dir_now == sap_pkg::SAP_DIR_IN && p3_now != 8'h00)
              begin
                st_reg <= sap_pkg::SAP_C_RXD; // R18
                len_reg <= {1'b0, p3_now}; // R3
              end
              else if (dir_now == sap_pkg::SAP_DIR_OUT && chk_ok)
              begin
                st_reg <= sap_pkg::SAP_C_TXD; // R18
                len_reg <= (p3_now == 8'h00) ? `SAP_LEN_MAX :
                           {1'b0, p3_now}; // R3
              end
              else
                st_reg <= sap_pkg::SAP_C_SW1; // R19
            end
          end
        sap_pkg::SAP_C_RXD:
          if (lnk.t2c_valid)
          begin
            len_reg <= len_reg - `SAP_LEN_ONE;
            if (len_reg == `SAP_LEN_ONE)
              st_reg <= sap_pkg::SAP_C_SW1; // R18
          end
        sap_pkg::SAP_C_TXD:
        begin
          len_reg <= len_reg - `SAP_LEN_ONE;
          if (len_reg == `SAP_LEN_ONE)
            st_reg <= sap_pkg::SAP_C_SW1; // R18
        end
        sap_pkg::SAP_C_SW1:
          st_reg <= sap_pkg::SAP_C_SW2;
        default:
          st_reg <= sap_pkg::SAP_C_HDR;
      endcase
    end
  end

  // link side: data then two status bytes, unchanged
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lnk.c2t_valid <= 1'b0;
      lnk.c2t_byte <= 8'h00;
      lnk.c2t_sw <= 1'b0;
    end
    else
    begin
      lnk.c2t_valid <= (st_reg == sap_pkg::SAP_C_TXD) ||
                       (st_reg == sap_pkg::SAP_C_SW1) ||
                       (st_reg == sap_pkg::SAP_C_SW2); // R1
      lnk.c2t_sw <= (st_reg == sap_pkg::SAP_C_SW1) ||
                    (st_reg == sap_pkg::SAP_C_SW2);
      if (st_reg == sap_pkg::SAP_C_TXD)
        lnk.c2t_byte <= tx_byte; // R5
      else if (st_reg == sap_pkg::SAP_C_SW1)
        lnk.c2t_byte <= sw1_out;
      else
        lnk.c2t_byte <= sw2_out;
    end
  end

  // application side; for a refused command no strobe or command field moves, rx_byte still follows the link
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_go <= 1'b0;
      cmd_ins <= 8'h00;
      cmd_p1 <= 8'h00;
      cmd_p2 <= 8'h00;
      cmd_p3 <= 8'h00;
      cmd_offset <= 16'h0000;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
      tx_take <= 1'b0;
    end
    else
    begin
      cmd_go <= (rx_last && ok_reg) || (hdr_done && chk_ok &&
                !(dir_now == sap_pkg::SAP_DIR_IN && p3_now != 8'h00)); // R9
      if (hdr_done && chk_ok)
      begin
        cmd_ins <= ins_reg; // R9 R14
        cmd_p1 <= p1_reg; // R4
        cmd_p2 <= p2_reg; // R4
        cmd_p3 <= p3_now; // R4
        cmd_offset <= {p1_reg, p2_reg}; // R10
      end
      rx_valid <= (st_reg == sap_pkg::SAP_C_RXD) && lnk.t2c_valid &&
                  ok_reg; // R9
      rx_byte <= lnk.t2c_byte; // R5
      tx_take <= st_reg == sap_pkg::SAP_C_TXD;
    end
  end
endmodule

// [logic/sap_term.sv]
// terminal end: sends a header and data, gathers data and status
// fetches announced data on its own when auto_get is high
`timescale 1ns/1ps
`include "sap_map.svh"
module sap_term (
  input wire logic sys_clk,
  input wire logic reset_n,
  sap_if.term lnk,
  input wire logic start,
  input wire logic [7:0] s_ins,
  input wire logic [7:0] s_p1,
  input wire logic [7:0] s_p2,
  input wire logic [7:0] s_p3,
  input wire logic auto_get,
  input wire logic [7:0] tx_byte,
  output logic tx_take,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic done,
  output logic [7:0] sw1,
  output logic [7:0] sw2,
  output logic busy
);
  sap_pkg::sap_host_st_e st_reg;
  logic [7:0] hb_reg [0:4];
  logic [2:0] hc_reg;
  logic [7:0] len_reg;
  logic swc_reg;
  logic [7:0] sw1_reg;
  logic sw_end;
  logic fetch;

  assign sw_end = (st_reg == sap_pkg::SAP_H_RXW) && lnk.c2t_valid &&
                  lnk.c2t_sw && swc_reg;
  assign fetch = auto_get && ((sw1_reg == `SAP_SW1_PEND) ||
                 (sw1_reg == `SAP_SW1_PEND_DL)); // R7 R8

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg <= sap_pkg::SAP_H_IDLE;
      for (int i = 0; i < 5; i++)
        hb_reg[i] <= 8'h00;
      hc_reg <= 3'h0;
      len_reg <= 8'h00;
      swc_reg <= 1'b0;
      sw1_reg <= 8'h00;
    end
    else
    begin
      case (st_reg)
        sap_pkg::SAP_H_IDLE:
          if (start)
          begin
            hb_reg[0] <= `SAP_CLA_GSM; // R2
            hb_reg[1] <= s_ins;
            hb_reg[2] <= s_p1;
            hb_reg[3] <= s_p2;
            hb_reg[4] <= s_p3;
            hc_reg <= 3'h0;
            st_reg <= sap_pkg::SAP_H_HDR;
          end
        sap_pkg::SAP_H_HDR:
        begin
          hc_reg <= hc_reg + 3'h1;
          swc_reg <= 1'b0;
          if (hc_reg == `SAP_HDR_LAST)
          begin
            len_reg <= hb_reg[4];
            if (sap_pkg::sap_dir(hb_reg[1]) == sap_pkg::SAP_DIR_IN &&
                hb_reg[4] != 8'h00) // R3
              st_reg <= sap_pkg::SAP_H_TXD;
            else
              st_reg <= sap_pkg::SAP_H_RXW; // R17
          end
        end
        sap_pkg::SAP_H_TXD:
        begin
          len_reg <= len_reg - 8'h01;
          if (len_reg == 8'h01)
            st_reg <= sap_pkg::SAP_H_RXW; // R18
        end
        default:
          if (lnk.c2t_valid && lnk.c2t_sw)
          begin
            swc_reg <= 1'b1;
            if (!swc_reg)
              sw1_reg <= lnk.c2t_byte;
            else if (fetch)
            begin
              hb_reg[0] <= `SAP_CLA_GSM;
              hb_reg[1] <= `SAP_INS_GET_RESP; // R7 R13
              hb_reg[2] <= `SAP_PZERO;
              hb_reg[3] <= `SAP_PZERO;
              hb_reg[4] <= lnk.c2t_byte; // R7
              hc_reg <= 3'h0;
              st_reg <= sap_pkg::SAP_H_HDR;
            end
            else
              st_reg <= sap_pkg::SAP_H_IDLE;
          end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lnk.t2c_valid <= 1'b0;
      lnk.t2c_byte <= 8'h00;
      tx_take <= 1'b0;
    end
    else
    begin
      lnk.t2c_valid <= (st_reg == sap_pkg::SAP_H_HDR) ||
                       (st_reg == sap_pkg::SAP_H_TXD); // R1
      lnk.t2c_byte <= (st_reg == sap_pkg::SAP_H_HDR) ? hb_reg[hc_reg] :
                      tx_byte; // R5
      tx_take <= st_reg == sap_pkg::SAP_H_TXD;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
      done <= 1'b0;
      sw1 <= 8'h00;
      sw2 <= 8'h00;
      busy <= 1'b0;
    end
    else
    begin
      rx_valid <= (st_reg == sap_pkg::SAP_H_RXW) && lnk.c2t_valid &&
                  !lnk.c2t_sw;
      rx_byte <= lnk.c2t_byte;
      done <= sw_end && !fetch;
      if (sw_end)
      begin
        sw1 <= sw1_reg;
        sw2 <= lnk.c2t_byte;
      end
      busy <= (st_reg != sap_pkg::SAP_H_IDLE) || start;
    end
  end
endmodule

// [verif/sap_link_assertions.sv]
// checker for the byte link between terminal and card ends
// takes the link signals as plain inputs; one clock, async low reset
`timescale 1ns/1ps
module sap_link_assertions (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic t2c_valid,
  input wire logic [7:0] t2c_byte,
  input wire logic c2t_valid,
  input wire logic [7:0] c2t_byte,
  input wire logic c2t_sw
);
  logic [2:0] hdr_reg;
  logic [7:0] ins_reg, p3_reg, sw1_reg, pend_reg;
  logic [8:0] tcnt_reg, dcnt_reg;
  logic sw_reg, fin, in_c, out_c, rsv_c;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  assign fin = c2t_valid && c2t_sw && sw_reg;
  assign in_c = ins_reg inside {8'hA4, 8'hD6, 8'hDC, 8'hA2, 8'h32, 8'h20,
    8'h24, 8'h26, 8'h28, 8'h2C, 8'h88, 8'h10, 8'hC2, 8'h14};
  assign out_c = ins_reg inside {8'hF2, 8'hB0, 8'hB2, 8'hC0, 8'h12};
  assign rsv_c = ins_reg inside {8'h16, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h2A,
    8'hD0, 8'hD2, 8'hDE, 8'hC4, 8'hC6, 8'hC8, 8'hCA, 8'hCC, 8'hB4, 8'hB6,
    8'hB8, 8'hBA, 8'hBC};
  // header byte position, cleared by the second status byte
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      hdr_reg <= 3'h0;
    else if (fin)
      hdr_reg <= 3'h0;
    else if (t2c_valid && hdr_reg != 3'h5)
      hdr_reg <= hdr_reg + 3'h1;
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ins_reg <= 8'h00;
      p3_reg <= 8'h00;
    end
    else if (t2c_valid && hdr_reg == 3'h1)
      ins_reg <= t2c_byte;
    else if (t2c_valid && hdr_reg == 3'h4)
      p3_reg <= t2c_byte;
  end
  // data bytes each way within one command
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tcnt_reg <= 9'h000;
      dcnt_reg <= 9'h000;
    end
    else if (fin)
    begin
      tcnt_reg <= 9'h000;
      dcnt_reg <= 9'h000;
    end
    else
    begin
      if (t2c_valid && hdr_reg == 3'h5)
        tcnt_reg <= tcnt_reg + 9'h001;
      if (c2t_valid && !c2t_sw)
        dcnt_reg <= dcnt_reg + 9'h001;
    end
  end
  // status phase and last announced length
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sw_reg <= 1'h0;
      sw1_reg <= 8'h00;
      pend_reg <= 8'h00;
    end
    else if (c2t_valid && c2t_sw)
    begin
      sw_reg <= !sw_reg;
      if (!sw_reg)
        sw1_reg <= c2t_byte;
      else if (sw1_reg inside {8'h9F, 8'h9E})
        pend_reg <= c2t_byte;
    end
  end
  sequence s_gap;
    !c2t_valid ##1 c2t_valid;
  endsequence
  sequence s_gap_sw;
    !c2t_valid ##1 (c2t_valid && c2t_sw);
  endsequence
  property p_sw_qual;
    c2t_sw |-> c2t_valid;
  endproperty
  a_sw_qual: assert property (p_sw_qual)
    else $error("status flag without a valid byte");
  property p_sw_pair;
    c2t_valid && c2t_sw && !sw_reg |=> c2t_valid && c2t_sw;
  endproperty
  a_sw_pair: assert property (p_sw_pair)
    else $error("first status byte not followed by second");
  property p_cla;
    t2c_valid && hdr_reg == 3'h0 |-> t2c_byte == 8'hA0;
  endproperty
  a_cla: assert property (p_cla)
    else $error("terminal class byte wrong");
  property p_ans_lat;
    t2c_valid && hdr_reg == 3'h4 && (!in_c || t2c_byte == 8'h00) |=> s_gap;
  endproperty
  a_ans_lat: assert property (p_ans_lat)
    else $error("card answer not two cycles after header");
  property p_in_lat;
    t2c_valid && hdr_reg == 3'h5 && in_c &&
      tcnt_reg + 9'h001 == {1'h0, p3_reg} |=> s_gap_sw;
  endproperty
  a_in_lat: assert property (p_in_lat)
    else $error("status not two cycles after last data byte");
  property p_out_cnt;
    c2t_valid && c2t_sw && !sw_reg && c2t_byte == 8'h90 && out_c |->
      dcnt_reg == ((p3_reg == 8'h00) ? 9'h100 : {1'h0, p3_reg});
  endproperty
  a_out_cnt: assert property (p_out_cnt)
    else $error("outgoing data count differs from length");
  property p_in_cnt;
    c2t_valid && c2t_sw && !sw_reg && in_c |-> tcnt_reg == {1'h0, p3_reg};
  endproperty
  a_in_cnt: assert property (p_in_cnt)
    else $error("incoming data count differs from length");
  property p_rsv;
    c2t_valid && hdr_reg == 3'h5 && rsv_c |->
      c2t_sw && (sw_reg || c2t_byte == 8'h6D);
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved code not refused");
  property p_gr_len;
    t2c_valid && hdr_reg == 3'h4 && ins_reg == 8'hC0 |->
      t2c_byte == pend_reg;
  endproperty
  a_gr_len: assert property (p_gr_len)
    else $error("fetch length differs from announced length");
  property p_gr_no_in;
    hdr_reg == 3'h5 && ins_reg == 8'hC0 |-> !t2c_valid;
  endproperty
  a_gr_no_in: assert property (p_gr_no_in)
    else $error("fetch command carries input data");
endmodule

// [verif/test_sim_apdu_command_decoder.sv]
// self-checking bench: terminal and card joined by one link, plus a
// second card fed byte by byte with A0 and foreign class headers; 250 MHz
`timescale 1ns/1ps
module test_sim_apdu_command_decoder;
  logic sys_clk, reset_n, start, auto_get, dl, go, go2, crx_v, trx_v;
  logic done, ph2, ctk, ttk, bsy;
  logic [7:0] s_ins, s_p1, s_p2, s_p3, t_byte, c_byte, pl, crx_b, trx_b;
  logic [7:0] sw1, sw2, s1_2, ci, cp1, cp2, cp3;
  logic [15:0] off, off2, seed, exp_off, exp_ip;
  logic [15:0] q [$];
  logic [50:0] tab [0:28];
  logic [7:0] rsv [0:18] = '{8'h16, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h2A,
    8'hD0, 8'hD2, 8'hDE, 8'hC4, 8'hC6, 8'hC8, 8'hCA, 8'hCC, 8'hB4, 8'hB6,
    8'hB8, 8'hBA, 8'hBC};
  int err_total, compares, crx_n, trx_n, go_n, go2_n, got, ctk_n, ttk_n;
  sap_if lnk();
  sap_if lnk2();
  sap_card i_sap_card (.sys_clk(sys_clk), .reset_n(reset_n), .lnk(lnk),
    .cmd_go(go), .cmd_ins(ci), .cmd_p1(cp1), .cmd_p2(cp2), .cmd_p3(cp3),
    .cmd_offset(off), .rx_valid(crx_v), .rx_byte(crx_b), .tx_take(ctk),
    .tx_byte(c_byte), .pend_len(pl), .dl_pend(dl));
  sap_card i_sap_card_b (.sys_clk(sys_clk), .reset_n(reset_n), .lnk(lnk2),
    .cmd_go(go2), .cmd_ins(), .cmd_p1(), .cmd_p2(), .cmd_p3(),
    .cmd_offset(off2), .rx_valid(), .rx_byte(), .tx_take(),
    .tx_byte(c_byte), .pend_len(pl), .dl_pend(dl));
  sap_term i_sap_term (.sys_clk(sys_clk), .reset_n(reset_n), .lnk(lnk),
    .start(start), .s_ins(s_ins), .s_p1(s_p1), .s_p2(s_p2), .s_p3(s_p3),
    .auto_get(auto_get), .tx_byte(t_byte), .tx_take(ttk), .rx_valid(trx_v),
    .rx_byte(trx_b), .done(done), .sw1(sw1), .sw2(sw2), .busy(bsy));
  sap_link_assertions i_sap_link_assertions (.sys_clk(sys_clk),
    .reset_n(reset_n), .t2c_valid(lnk.t2c_valid), .t2c_byte(lnk.t2c_byte),
    .c2t_valid(lnk.c2t_valid), .c2t_byte(lnk.c2t_byte),
    .c2t_sw(lnk.c2t_sw));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one command through the terminal; e = kind, pend, header, status
  task automatic run(input logic [50:0] e, input logic ag);
    logic [1:0] kind;
    logic pend, acc;
    logic [7:0] x1, x2;
    int g, nin, nout, ngo, nt;
    {kind, pend, s_ins, s_p1, s_p2, s_p3, x1, x2} = e;
    seed = lfsr(seed);
    t_byte = seed[7:0];
    c_byte = seed[11:4];
    pl = seed[15:8] | 8'h01;
    dl = seed[3];
    auto_get = ag;
    acc = x1 == 8'h90;
    if (pend && !ag)
    begin
      x1 = (s_ins == 8'hC2 && dl) ? 8'h9E : 8'h9F;
      x2 = pl;
    end
    nin = (acc && kind == 2'h1) ? s_p3 : 0;
    nout = 0;
    if (acc && pend && ag)
      nout = pl;
    else if (acc && kind == 2'h2)
      nout = (s_p3 == 8'h00) ? 256 : s_p3;
    ngo = acc ? ((pend && ag) ? 2 : 1) : 0;
    if (acc)
    begin
      exp_off = (pend && ag) ? 16'h0000 : {s_p1, s_p2};
      exp_ip = (pend && ag) ? {8'hC0, pl} : {s_ins, s_p3};
    end
    nt = (kind == 2'h1) ? s_p3 : 0;
    q.push_back({x1, x2});
    crx_n = 0;
    trx_n = 0;
    go_n = 0;
    ctk_n = 0;
    ttk_n = 0;
    g = got;
    start = 1'h1;
    @(negedge sys_clk);
    start = 1'h0;
    for (int k = 0; k < 3000 && got == g; k++)
      @(negedge sys_clk);
    repeat (3) @(negedge sys_clk);
    chk(crx_n[15:0], nin[15:0]);
    chk(trx_n[15:0], nout[15:0]);
    chk(go_n[15:0], ngo[15:0]);
    chk(off, exp_off);
    chk({cp1, cp2}, exp_off);
    chk({ci, cp3}, exp_ip);
    chk(ctk_n[15:0], nout[15:0]);
    chk(ttk_n[15:0], nt[15:0]);
    chk(16'(got - g), 16'h0001);
    chk({15'h0000, bsy}, 16'h0000);
  endtask
  // raw header into the second card
  task automatic raw(input logic [39:0] h, input logic [15:0] sw,
    input logic [15:0] oexp);
    int g;
    g = got;
    q.push_back(sw);
    for (int i = 4; i >= 0; i--)
    begin
      lnk2.t2c_valid = 1'h1;
      lnk2.t2c_byte = h[i * 8 +: 8];
      @(negedge sys_clk);
    end
    lnk2.t2c_valid = 1'h0;
    lnk2.t2c_byte = ~lnk2.t2c_byte;
    for (int k = 0; k < 300 && got == g; k++)
      @(negedge sys_clk);
    repeat (3) @(negedge sys_clk);
    chk(go2_n[15:0], 16'h0001);
    chk(off2, oexp);
    chk(16'(got - g), 16'h0001);
  endtask
  always @(negedge sys_clk)
  begin
    if (reset_n)
    begin
      if (crx_v)
      begin
        crx_n++;
        chk({8'h00, crx_b}, {8'h00, t_byte});
      end
      if (trx_v)
      begin
        trx_n++;
        chk({8'h00, trx_b}, {8'h00, c_byte});
      end
      if (go)
        go_n++;
      if (go2)
        go2_n++;
      if (ctk)
        ctk_n++;
      if (ttk)
        ttk_n++;
      if (done)
      begin
        got++;
        chk({sw1, sw2}, q.pop_front());
      end
      if (lnk2.c2t_valid && lnk2.c2t_sw && !ph2)
      begin
        s1_2 = lnk2.c2t_byte;
        ph2 = 1'h1;
      end
      else if (lnk2.c2t_valid && lnk2.c2t_sw)
      begin
        ph2 = 1'h0;
        got++;
        chk({s1_2, lnk2.c2t_byte}, q.pop_front());
      end
    end
  end
  initial
  begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    #300000;
    err_total++;
    $display("ERROR %0t: run did not finish", $time);
    stop_test();
  end
  initial
  begin
    reset_n = 1'h0;
    {start, auto_get, dl, ph2} = 4'h0;
    {s_ins, s_p1, s_p2, s_p3, t_byte, c_byte} = 48'h0;
    pl = 8'h01;
    exp_off = 16'h0000;
    exp_ip = 16'h0000;
    lnk2.t2c_valid = 1'h0;
    lnk2.t2c_byte = 8'h00;
    seed = 16'hFA76;
    tab = '{{3'h3, 48'hA40000029000}, {3'h2, 48'hA40001026B00},
      {3'h2, 48'hA40000036700}, {3'h4, 48'hB0FFFFFF9000},
      {3'h4, 48'hB00001009000}, {3'h2, 48'hD60000009000},
      {3'h2, 48'hD61234059000}, {3'h4, 48'hB201040A9000},
      {3'h2, 48'hDC02040A9000}, {3'h3, 48'hA20010049000},
      {3'h3, 48'h320000039000}, {3'h2, 48'h320000046700},
      {3'h2, 48'h200001089000}, {3'h2, 48'h240002109000},
      {3'h2, 48'h260001089000}, {3'h2, 48'h260002086B00},
      {3'h2, 48'h280001089000}, {3'h2, 48'h2C0000109000},
      {3'h2, 48'h2C0002109000}, {3'h2, 48'h2C0001106B00},
      {3'h4, 48'hF20000169000}, {3'h3, 48'hC20000059000},
      {3'h4, 48'h120000049000}, {3'h2, 48'h100000039000},
      {3'h2, 48'h140000029000}, {3'h3, 48'h880000109000},
      {3'h0, 48'h040000009000}, {3'h0, 48'h440000009000},
      {3'h0, 48'hFA0000009000}};
    repeat (16) @(negedge sys_clk);
    reset_n = 1'h1;
    raw(40'hA0B0123401, 16'h9000, 16'h1234);
    raw(40'h55B0567801, 16'h6E00, 16'h1234);
    raw(40'h80D6000000, 16'h6E00, 16'h1234);
    repeat (3)
    begin
      run({3'h3, 48'hA40000029000}, 1'h0);
      run({3'h3, 48'hC20000059000}, 1'h0);
    end
    foreach (tab[i])
      run(tab[i], 1'h1);
    foreach (rsv[i])
      run({3'h0, rsv[i], 24'h000000, 16'h6D00}, 1'h1);
    chk(16'(q.size()), 16'h0000);
    stop_test();
  end
endmodule
